// *** core/bcs_defines.svh ***
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH

// ==========================================
// configuration offsets
`define BCS_CMD_OFS        8'h04
`define BCS_STS_OFS        8'h06
`define BCS_CMD_DW_IDX     6'h01

// ==========================================
// command register fields
`define BCS_CMD_IO_BIT     0
`define BCS_CMD_MEM_BIT    1
`define BCS_CMD_BME_BIT    2
`define BCS_CMD_SERR_BIT   8
`define BCS_CMD_RESET      16'h0000
`define BCS_CMD_WR_MASK    16'h0107

// ==========================================
// status register fields
`define BCS_STS_SSE_BIT    14
`define BCS_STS_FIXED      16'h0020
`define BCS_STS_RESET      16'h0020
`define BCS_STS_SSE_BYTE   3
`define BCS_STS_SPEED_BIT  5

// ==========================================
// pin input widths
`define BCS_PIN_W          2

`endif

// *** core/bcs_pkg.sv ***
package bcs_pkg;

   // ==========================================
   // configuration access request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [5:0]  dw_addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bcs_cfg_req_t;

   // ==========================================
   // address decode results from the range comparators
   typedef struct packed {
      logic frame_hit;
      logic mem_hit;
      logic pref_hit;
      logic vga_hit;
      logic io_hit;
   } bcs_decode_t;

endpackage

// *** core/bcs_sync.sv ***
`timescale 1ns/10ps
`include "bcs_defines.svh"

module bcs_sync
   import bcs_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_sync_b,
   input  wire logic [`BCS_PIN_W-1:0] pin_in,
   output logic      [`BCS_PIN_W-1:0] pin_sync
);

   // ==========================================
   // two-stage synchroniser
   logic [`BCS_PIN_W-1:0] meta_r;

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         meta_r   <= '0;
         pin_sync <= '0;
      end else begin
         meta_r   <= pin_in;
         pin_sync <= meta_r;
      end
   end

endmodule

// *** core/bcs_regs.sv ***
`timescale 1ns/10ps
`include "bcs_defines.svh"

// Behaviour
// - own enable gates this function's error messages
// - errors reported by hub message, no pin
// - message mechanism enabled by OR of enables
// - bus master clear: ignore master cycles, abort
// - bus master set: accept only decode hits
// - sideband and pipelined requests ignore bus master
// - memory enable clear disables memory decoding
// - memory enable set decodes memory, prefetch, vga
// - io enable gates io range decoding
// - unimplemented command bits read zero
// - read-only command bits read zero
// - system error flag set on message
// - write one clears system error flag
// - abort and parity status bits read zero
// - target abort, data parity, fast b2b zero
// - devsel timing field reads zero
// - speed capability bit reads one
module bcs_regs
   import bcs_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire bcs_cfg_req_t cfg_req,
   output logic [31:0]       cfg_rdata_r,
   output logic              cfg_rvalid_r,
   input  wire logic         agp_frame_pin,
   input  wire logic         agp_pipe_pin,
   input  wire bcs_decode_t  decode,
   output logic              frame_accept_r,
   output logic              frame_abort_r,
   output logic              pipe_accept_r,
   output logic              mem_decode_r,
   output logic              io_decode_r,
   input  wire logic         err_event,
   input  wire logic         host_serr_en,
   output logic              syserr_msg_r,
   output logic              syserr_mech_en_r
);

   // ==========================================
   // reset release
   logic rst_meta_r;
   logic rst_sync_b;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_r <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_b <= rst_meta_r;
      end
   end

   // ==========================================
   // helpers
   function automatic logic hits_cmd(input logic [5:0] dw);
      hits_cmd = (dw == `BCS_CMD_DW_IDX);
   endfunction

   // ==========================================
   // register state
   logic [15:0] cmd_r;
   logic        sse_r;
   logic [15:0] cmd_nxt;
   logic [15:0] sts_view;
   logic        cmd_wr;
   logic        sse_clr;
   logic        msg_fire;

   assign cmd_wr  = cfg_req.wr && hits_cmd(cfg_req.dw_addr);
   assign sse_clr = cmd_wr && cfg_req.be[`BCS_STS_SSE_BYTE]
                    && cfg_req.wdata[16 + `BCS_STS_SSE_BIT];

   always_comb begin
      cmd_nxt = cmd_r;
      if (cfg_req.be[0]) begin
         cmd_nxt[7:0] = cfg_req.wdata[7:0];
      end
      if (cfg_req.be[1]) begin
         cmd_nxt[15:8] = cfg_req.wdata[15:8];
      end
      cmd_nxt = cmd_nxt & `BCS_CMD_WR_MASK;
   end

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cmd_r <= `BCS_CMD_RESET;
      end else if (cmd_wr) begin
         cmd_r <= cmd_nxt;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         sse_r <= 1'b0;
      end else if (msg_fire) begin
         sse_r <= 1'b1;
      end else if (sse_clr) begin
         sse_r <= 1'b0;
      end
   end

   // fixed status bits plus the one live flag
   always_comb begin
      sts_view = `BCS_STS_FIXED;
      sts_view[`BCS_STS_SSE_BIT] = sse_r;
   end

   // ==========================================
   // configuration read port
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cfg_rdata_r  <= 32'h00000000;
         cfg_rvalid_r <= 1'b0;
      end else begin
         cfg_rvalid_r <= cfg_req.rd;
         if (cfg_req.rd && hits_cmd(cfg_req.dw_addr)) begin
            cfg_rdata_r <= {sts_view, cmd_r};
         end else begin
            cfg_rdata_r <= 32'h00000000;
         end
      end
   end

   // ==========================================
   // agp pin inputs
   logic [`BCS_PIN_W-1:0] pin_sync;
   logic                  frame_d_r;
   logic                  pipe_d_r;
   logic                  frame_start;
   logic                  pipe_start;

   bcs_sync u_sync (
      .clk_sys    (clk_sys),
      .rst_sync_b (rst_sync_b),
      .pin_in     ({agp_pipe_pin, agp_frame_pin}),
      .pin_sync   (pin_sync)
   );

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         frame_d_r <= 1'b0;
         pipe_d_r  <= 1'b0;
      end else begin
         frame_d_r <= pin_sync[0];
         pipe_d_r  <= pin_sync[1];
      end
   end

   assign frame_start = pin_sync[0] && !frame_d_r;
   assign pipe_start  = pin_sync[1] && !pipe_d_r;

   // ==========================================
   // master cycle acceptance
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         frame_accept_r <= 1'b0;
         frame_abort_r  <= 1'b0;
      end else begin
         frame_accept_r <= frame_start && cmd_r[`BCS_CMD_BME_BIT]
                           && decode.frame_hit;
         frame_abort_r  <= frame_start && !(cmd_r[`BCS_CMD_BME_BIT]
                           && decode.frame_hit);
      end
   end

   // pipelined and sideband requests bypass bus master gating
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         pipe_accept_r <= 1'b0;
      end else begin
         pipe_accept_r <= pipe_start;
      end
   end

   // ==========================================
   // memory and io decode gating
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         mem_decode_r <= 1'b0;
         io_decode_r  <= 1'b0;
      end else begin
         mem_decode_r <= cmd_r[`BCS_CMD_MEM_BIT]
                         && (decode.mem_hit || decode.pref_hit
                             || decode.vga_hit);
         io_decode_r  <= cmd_r[`BCS_CMD_IO_BIT] && decode.io_hit;
      end
   end

   // ==========================================
   // system error messaging
   assign msg_fire = err_event && cmd_r[`BCS_CMD_SERR_BIT];

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         syserr_msg_r     <= 1'b0;
         syserr_mech_en_r <= 1'b0;
      end else begin
         syserr_msg_r     <= msg_fire;
         syserr_mech_en_r <= cmd_r[`BCS_CMD_SERR_BIT] || host_serr_en;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_sync_b);

   a_frame_ignored: assert property (
      frame_start && !cmd_r[`BCS_CMD_BME_BIT]
      |=> frame_abort_r && !frame_accept_r)
      else $error("master cycle not ignored with bus master clear");

   a_frame_hit_ok: assert property (
      frame_start && cmd_r[`BCS_CMD_BME_BIT] && decode.frame_hit
      |=> frame_accept_r && !frame_abort_r)
      else $error("decoded master cycle not accepted");

   a_frame_miss: assert property (
      frame_accept_r |-> $past(decode.frame_hit) && $past(frame_start))
      else $error("accept without decode hit");

   a_pipe_free: assert property (
      pipe_start |=> pipe_accept_r)
      else $error("pipelined request dropped");

   a_mem_gate: assert property (
      !cmd_r[`BCS_CMD_MEM_BIT] |=> !mem_decode_r)
      else $error("memory decode while disabled");

   a_mem_ranges: assert property (
      cmd_r[`BCS_CMD_MEM_BIT] && (decode.vga_hit || decode.pref_hit)
      |=> mem_decode_r)
      else $error("enabled memory window not decoded");

   a_io_gate: assert property (
      io_decode_r |-> $past(cmd_r[`BCS_CMD_IO_BIT]) && $past(decode.io_hit))
      else $error("io decode without enable and hit");

   a_cmd_zero: assert property (
      cfg_rvalid_r |-> (cfg_rdata_r[15:0] & ~`BCS_CMD_WR_MASK) == 16'h0000)
      else $error("fixed command bits read nonzero");

   a_sts_fixed: assert property (
      cfg_rvalid_r && $past(hits_cmd(cfg_req.dw_addr))
      |-> (cfg_rdata_r[31:16] & 16'hBFFF) == `BCS_STS_FIXED)
      else $error("fixed status bits wrong");

   a_msg_enable: assert property (
      syserr_msg_r |-> $past(cmd_r[`BCS_CMD_SERR_BIT]))
      else $error("message sent while own enable clear");

   a_sse_set: assert property (
      msg_fire |=> sse_r && syserr_msg_r)
      else $error("flag not set with message");

   a_sse_clear: assert property (
      sse_clr && !msg_fire |=> !sse_r)
      else $error("write one did not clear flag");

   a_sse_hold: assert property (
      cmd_wr && !sse_clr && !msg_fire |=> sse_r == $past(sse_r))
      else $error("write zero changed flag");

   a_mech_or: assert property (
      host_serr_en |=> syserr_mech_en_r)
      else $error("host enable did not enable mechanism");

   a_mech_own: assert property (
      cmd_r[`BCS_CMD_SERR_BIT] |=> syserr_mech_en_r)
      else $error("own enable did not enable mechanism");

   a_mech_off: assert property (
      !cmd_r[`BCS_CMD_SERR_BIT] && !host_serr_en |=> !syserr_mech_en_r)
      else $error("mechanism enabled with both enables clear");

   a_msg_fires: assert property (
      err_event && cmd_r[`BCS_CMD_SERR_BIT] |=> syserr_msg_r)
      else $error("enabled error sent no message");

   a_msg_cause: assert property (
      syserr_msg_r |-> $past(err_event))
      else $error("message without error event");

   a_sse_sticky: assert property (
      sse_r && !sse_clr |=> sse_r)
      else $error("flag dropped without clear");

   a_cmd_fixed: assert property (
      cmd_wr |=> cmd_r[15:9] == 7'h00 && cmd_r[7:3] == 5'h00)
      else $error("fixed command bits took a write");

   a_cmd_low_wr: assert property (
      cmd_wr && cfg_req.be[0] |=> cmd_r[2:0] == $past(cfg_req.wdata[2:0]))
      else $error("low command bits not written");

   a_cmd_serr_wr: assert property (
      cmd_wr && cfg_req.be[1]
      |=> cmd_r[`BCS_CMD_SERR_BIT] == $past(cfg_req.wdata[`BCS_CMD_SERR_BIT]))
      else $error("message enable not written");

   a_cmd_hold: assert property (
      !cmd_wr |=> $stable(cmd_r))
      else $error("command changed without write");

   a_abort_cause: assert property (
      frame_abort_r |-> $past(frame_start))
      else $error("abort without master cycle");

   a_pipe_cause: assert property (
      pipe_accept_r |-> $past(pipe_start))
      else $error("pipelined accept without request");

   a_io_off: assert property (
      !cmd_r[`BCS_CMD_IO_BIT] |=> !io_decode_r)
      else $error("io decode while disabled");

   a_mem_plain: assert property (
      cmd_r[`BCS_CMD_MEM_BIT] && decode.mem_hit |=> mem_decode_r)
      else $error("enabled memory range not decoded");

   a_speed_one: assert property (
      cfg_req.rd && hits_cmd(cfg_req.dw_addr)
      |=> cfg_rdata_r[16 + `BCS_STS_SPEED_BIT])
      else $error("speed capability bit not one");

endmodule

// *** testbench/bcs_agp_master.sv ***
`timescale 1ns/10ps
// ==========================================
// agp master: raises one request pin, drops it once answered
module bcs_agp_master (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic go,
   input  wire logic pipe_sel,
   input  wire logic done,
   output logic      frame_pin,
   output logic      pipe_pin
);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         frame_pin <= 1'b0;
         pipe_pin  <= 1'b0;
      end else if (go) begin
         frame_pin <= !pipe_sel;
         pipe_pin  <= pipe_sel;
      end else if (done) begin
         frame_pin <= 1'b0;
         pipe_pin  <= 1'b0;
      end
   end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/10ps
module tb
   import bcs_pkg::*;
;
   logic         clk_sys, rst_b, err_event, host_serr_en, go, pipe_sel;
   bcs_cfg_req_t req;
   bcs_decode_t  dec;
   logic [31:0]  rdata;
   logic         rvalid, acc, abt, pacc, memd, iod, msg, mech, frame_pin, pipe_pin;
   logic [15:0]  cmd_m;
   logic         sse_m;
   int           mismatches, comparisons;

   bcs_regs dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_req(req), .cfg_rdata_r(rdata),
      .cfg_rvalid_r(rvalid), .agp_frame_pin(frame_pin), .agp_pipe_pin(pipe_pin),
      .decode(dec), .frame_accept_r(acc), .frame_abort_r(abt), .pipe_accept_r(pacc),
      .mem_decode_r(memd), .io_decode_r(iod), .err_event(err_event),
      .host_serr_en(host_serr_en), .syserr_msg_r(msg), .syserr_mech_en_r(mech));

   bcs_agp_master agp_u (.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .pipe_sel(pipe_sel),
      .done(acc | abt | pacc), .frame_pin(frame_pin), .pipe_pin(pipe_pin));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // ==========================================
   // checking helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask

   task automatic complete_run();
      $display("counts comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   function automatic logic [31:0] exp_rd(input logic [5:0] a);
      return (a == 6'h01) ? {1'b0, sse_m, 14'h0020, cmd_m} : 32'h0000_0000;
   endfunction

   // ==========================================
   // stimulus tasks
   task automatic cfg_rd(input logic [5:0] a);
      @(posedge clk_sys);
      req <= '{rd: 1'b1, wr: 1'b0, dw_addr: a, be: 4'hF, wdata: 32'h0};
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1;
      chk(32'(rvalid), 32'h1);
      chk(rdata, exp_rd(a));
   endtask

   task automatic cfg_wr(input logic [5:0] a, input logic [31:0] w, input logic [3:0] be);
      @(posedge clk_sys);
      req <= '{rd: 1'b0, wr: 1'b1, dw_addr: a, be: be, wdata: w};
      @(posedge clk_sys);
      req.wr <= 1'b0;
      #1;
      if (a == 6'h01) begin
         if (be[0]) cmd_m[2:0] = w[2:0];
         if (be[1]) cmd_m[8] = w[8];
         if (be[3] && w[30]) sse_m = 1'b0;
      end
   endtask

   task automatic raise_err(input logic h);
      @(posedge clk_sys);
      err_event <= 1'b1;
      host_serr_en <= h;
      @(posedge clk_sys);
      err_event <= 1'b0;
      #1;
      chk(32'(msg), 32'(cmd_m[8]));
      chk(32'(mech), 32'(cmd_m[8] | h));
      sse_m = sse_m | cmd_m[8];
   endtask

   task automatic decode_chk();
      @(posedge clk_sys);
      dec <= 5'($urandom);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'(memd), 32'(cmd_m[1] & (dec.mem_hit | dec.pref_hit | dec.vga_hit)));
      chk(32'(iod), 32'(cmd_m[0] & dec.io_hit));
   endtask

   task automatic agp_cycle(input logic p);
      int n;
      @(posedge clk_sys);
      pipe_sel <= p;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      for (n = 0; n < 10; n++) begin
         @(posedge clk_sys);
         #1;
         if (acc | abt | pacc) break;
      end
      if (n == 10) begin
         $display("ERROR t=%0t agp timeout got=%h exp=%h", $time, 3'h0, 3'h7);
         mismatches++;
         complete_run();
      end else begin
         chk({acc, abt, pacc}, p ? 3'b001 : ((cmd_m[2] & dec.frame_hit) ? 3'b100 : 3'b010));
         repeat (4) @(posedge clk_sys);
      end
   endtask

   // ==========================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      req = '0;
      dec = '0;
      err_event = 1'b0;
      host_serr_en = 1'b0;
      go = 1'b0;
      pipe_sel = 1'b0;
      cmd_m = 16'h0000;
      sse_m = 1'b0;
      mismatches = 0;
      comparisons = 0;
      void'($urandom(32'hc565));
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk_sys);
      cfg_rd(6'h01);
      cfg_rd(6'h00);
      $display("test reset done");
      cfg_wr(6'h01, 32'hFFFF_FFFF, 4'h3);
      cfg_rd(6'h01);
      raise_err(1'b0);
      cfg_wr(6'h01, 32'h4000_0000, 4'h7);
      cfg_rd(6'h01);
      cfg_wr(6'h01, 32'h4000_0000, 4'h8);
      cfg_rd(6'h01);
      $display("test flag done");
      for (int i = 0; i < 60; i++) begin
         cfg_wr(($urandom % 4 == 0) ? 6'($urandom) : 6'h01, $urandom, 4'($urandom));
         cfg_rd(6'h01);
         raise_err(1'($urandom));
         decode_chk();
         agp_cycle(1'($urandom));
         agp_cycle(1'b1);
      end
      $display("test random done");
      complete_run();
   end
endmodule
